//--- hw/lrsr_cfg.svh
`ifndef LRSR_CFG_SVH
`define LRSR_CFG_SVH

// ****************************************************************
// Storage geometry of one lookup-table element.
// ****************************************************************
`define LRSR_RAM_DEPTH 16
`define LRSR_SRL_DEPTH 32
`define LRSR_ADDR_W 5
`define LRSR_RAM_ADDR_W 4
`define LRSR_LANES 2

// ****************************************************************
// Lane positions inside the two-bit arrangement.
// ****************************************************************
`define LRSR_LANE_FIRST 0
`define LRSR_LANE_SECOND 1

`endif

//--- hw/lrsr_pkg.sv
package lrsr_pkg;

  // ****************************************************************
  // Operating modes of the element.
  // ****************************************************************
  typedef enum logic {
    LRSR_MODE_RAM,
    LRSR_MODE_SHIFT
  } lrsr_mode_t;

  // Control presented by the surrounding logic.
  typedef struct packed {
    lrsr_mode_t mode;         // RAM or shift register.
    logic       write_en;     // Write enable, or clock enable when shifting.
    logic       wide;         // Two-bit arrangement uses the second lane too.
    logic       cascade_sel;  // Route the cascade tap onto the d multiplexer when shifting.
    logic [4:0] addr;         // Location or stage select.
  } lrsr_ctrl_t;

  // Everything the element shows to the slice around it.
  typedef struct packed {
    logic [1:0] lookup;            // Addressable output per lane.
    logic       slice_mux_out_a;   // First-lane multiplexer output.
    logic       slice_mux_out_d;   // Second multiplexer, lookup or cascade.
    logic       cascade_tap_out;   // Last shift stage of the first lane.
    logic       carry_chain_out;   // Carry output propagating the first lane.
    logic       read_valid;        // Low while the addressable value is unknown.
  } lrsr_out_t;

endpackage

//--- hw/lrsr_lut_ram_shift.sv
`timescale 1ns/100ps
`default_nettype none
`include "lrsr_cfg.svh"

module lrsr_lut_ram_shift #(
  parameter int RAM_DEPTH = `LRSR_RAM_DEPTH,
  parameter int SRL_DEPTH = `LRSR_SRL_DEPTH,
  parameter int ADDR_W = `LRSR_ADDR_W
) (
  input wire logic clk_in,                    // Element clock, rising edge active.
  input wire logic srst_in,                   // Synchronous reset of the status only.
  input wire lrsr_pkg::lrsr_ctrl_t ctrl_in,   // Mode, enables and address.
  input wire logic bypass_data_in,            // First data bit.
  input wire logic secondary_data_in,         // Second data bit.
  output var lrsr_pkg::lrsr_out_t lut_out     // Lookup, multiplexer and tap outputs.
);

  // ****************************************************************
  // Elaboration checks.
  // ****************************************************************
  // The address must cover the chain exactly and the RAM must fit in it.
  if (SRL_DEPTH != (1 << ADDR_W) || RAM_DEPTH > SRL_DEPTH || ADDR_W != 5) begin : g_bad_cfg
    $error("lrsr_lut_ram_shift: unsupported depth or address width");
  end

  // ****************************************************************
  // Storage and helpers.
  // ****************************************************************
  logic [SRL_DEPTH-1:0] mem_reg [`LRSR_LANES];
  logic [SRL_DEPTH-1:0] mem_next [`LRSR_LANES];
  logic [ADDR_W-1:0] addr_prev_reg;
  logic [ADDR_W-1:0] addr_prev_next;
  logic valid_reg;
  logic valid_next;
  logic shift_edge;
  logic ram_edge;
  logic [`LRSR_LANES-1:0] lane_data;
  logic [`LRSR_LANES-1:0] lane_en;

  // Selects one location; RAM mode only looks at the low address bits.
  function automatic logic lane_read(input logic [SRL_DEPTH-1:0] vec,
                                     input logic [ADDR_W-1:0] addr,
                                     input lrsr_pkg::lrsr_mode_t mode);
    logic [ADDR_W-1:0] idx;
    idx = addr;
    if (mode == lrsr_pkg::LRSR_MODE_RAM) begin
      idx = {1'b0, addr[`LRSR_RAM_ADDR_W-1:0]};
    end
    return vec[idx];
  endfunction

  assign shift_edge = ctrl_in.mode == lrsr_pkg::LRSR_MODE_SHIFT && ctrl_in.write_en;
  assign ram_edge = ctrl_in.mode == lrsr_pkg::LRSR_MODE_RAM && ctrl_in.write_en;
  // First bit always arrives on the bypass input, the second on the secondary one.
  assign lane_data = {secondary_data_in, bypass_data_in};
  // The second lane only moves in the two-bit arrangement.
  assign lane_en = {ctrl_in.wide, 1'b1};

  // ****************************************************************
  // Storage lanes.
  // ****************************************************************
  for (genvar l = 0; l < `LRSR_LANES; l++) begin : g_lane
    // Next contents: a single-location write in RAM mode, a one-stage shift otherwise.
    always_comb begin
      mem_next[l] = mem_reg[l];
      if (lane_en[l]) begin
        if (ram_edge) begin
          mem_next[l][ctrl_in.addr[`LRSR_RAM_ADDR_W-1:0]] = lane_data[l];
        end else if (shift_edge) begin
          mem_next[l] = {mem_reg[l][SRL_DEPTH-2:0], lane_data[l]};
        end
      end
    end

    // Contents carry no reset, so a reset never disturbs stored data.
    always_ff @(posedge clk_in) begin
      mem_reg[l] <= mem_next[l];
    end
  end

  // ****************************************************************
  // Address stability tracking.
  // ****************************************************************
  // An address that moves across a shifting edge leaves the read undefined until the
  // next edge at which the address is seen steady.
  always_comb begin
    addr_prev_next = ctrl_in.addr;
    valid_next = valid_reg;
    if (shift_edge && ctrl_in.addr != addr_prev_reg) begin
      valid_next = 1'b0;
    end else if (ctrl_in.addr == addr_prev_reg) begin
      valid_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      addr_prev_reg <= '0;
      valid_reg <= 1'b1;
    end else begin
      addr_prev_reg <= addr_prev_next;
      valid_reg <= valid_next;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  // Reads are a plain multiplexer on the stored bits, so a new address shows its
  // value within the same cycle; the price is a combinational path to the pins.
  always_comb begin
    lut_out.lookup[0] = lane_read(mem_reg[0], ctrl_in.addr, ctrl_in.mode);
    lut_out.lookup[1] = lane_read(mem_reg[1], ctrl_in.addr, ctrl_in.mode);
    lut_out.slice_mux_out_a = lut_out.lookup[0];
    lut_out.cascade_tap_out = mem_reg[0][SRL_DEPTH-1];
    lut_out.slice_mux_out_d = lut_out.lookup[1];
    if (ctrl_in.mode == lrsr_pkg::LRSR_MODE_SHIFT && ctrl_in.cascade_sel) begin
      lut_out.slice_mux_out_d = mem_reg[0][SRL_DEPTH-1];
    end
    lut_out.carry_chain_out = lut_out.lookup[0];
    lut_out.read_valid = valid_reg;
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  ram_write_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ram_edge |=> mem_reg[0][$past(ctrl_in.addr[3:0])] == $past(bypass_data_in))
    else $error("RAM write did not store the first data bit");

  ram_readback_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (ram_edge ##1 ($stable(ctrl_in.addr) && ctrl_in.mode == lrsr_pkg::LRSR_MODE_RAM))
    |-> lut_out.lookup[0] == $past(bypass_data_in))
    else $error("Lookup output does not show the written bit");

  mux_carry_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (ram_edge ##1 ($stable(ctrl_in.addr) && ctrl_in.mode == lrsr_pkg::LRSR_MODE_RAM))
    |-> lut_out.slice_mux_out_a == $past(bypass_data_in)
        && lut_out.carry_chain_out == $past(bypass_data_in))
    else $error("Multiplexer or carry output missed the written bit");

  hold_contents_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    !ctrl_in.write_en |=> mem_reg[0] === $past(mem_reg[0]) && mem_reg[1] === $past(mem_reg[1]))
    else $error("Contents changed without write enable");

  shift_step_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    shift_edge |=> mem_reg[0][SRL_DEPTH-1:1] === $past(mem_reg[0][SRL_DEPTH-2:0]))
    else $error("Shift did not move one stage");

  shift_in_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (shift_edge && ctrl_in.addr == 5'h00 ##1 ctrl_in.addr == 5'h00
     && ctrl_in.mode == lrsr_pkg::LRSR_MODE_SHIFT)
    |-> lut_out.lookup[0] == $past(bypass_data_in))
    else $error("Shifted bit not on the addressable output");

  cascade_tap_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    shift_edge |=> lut_out.cascade_tap_out === $past(mem_reg[0][SRL_DEPTH-2]))
    else $error("Cascade tap is not the last stage");

  second_lane_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (shift_edge && ctrl_in.wide) |=> mem_reg[1][0] == $past(secondary_data_in))
    else $error("Second lane did not shift with the first");

  narrow_lane_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    !ctrl_in.wide |=> mem_reg[1] === $past(mem_reg[1]))
    else $error("Second lane changed outside the two-bit arrangement");

  addr_unknown_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (shift_edge && ctrl_in.addr != addr_prev_reg) |=> !lut_out.read_valid)
    else $error("Moving address during a shift not flagged");

  // Contents start unknown, so the checks below compare stored bits by case equality, except the one-location count and bits just written or shifted in.
  // A RAM write must leave the upper half of the chain alone.
  ram_upper_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ram_edge |=> mem_reg[0][SRL_DEPTH-1:RAM_DEPTH] === $past(mem_reg[0][SRL_DEPTH-1:RAM_DEPTH]))
    else $error("RAM write touched a location above the RAM depth");

  // The second data bit lands in the second lane at the same location.
  ram_second_lane_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (ram_edge && ctrl_in.wide) |=> mem_reg[1][$past(ctrl_in.addr[3:0])] == $past(secondary_data_in))
    else $error("Second RAM lane missed its data bit");

  // At most one location may change on a RAM write.
  ram_one_loc_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ram_edge |=> $countones(mem_reg[0] ^ $past(mem_reg[0])) <= 1)
    else $error("RAM write changed more than one location");

  // RAM reads follow the applied address with no clock in between.
  ram_read_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ctrl_in.mode == lrsr_pkg::LRSR_MODE_RAM |-> lut_out.lookup[0] === mem_reg[0][ctrl_in.addr[3:0]])
    else $error("RAM read does not show the addressed location");

  // Shift reads pick the stage named by the full address in both lanes.
  shift_read_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    ctrl_in.mode == lrsr_pkg::LRSR_MODE_SHIFT
    |-> lut_out.lookup[0] === mem_reg[0][ctrl_in.addr] && lut_out.lookup[1] === mem_reg[1][ctrl_in.addr])
    else $error("Shift read does not show the addressed stage");

  // With the cascade selected in shift mode the d multiplexer carries the last stage.
  mux_d_tap_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (ctrl_in.mode == lrsr_pkg::LRSR_MODE_SHIFT && ctrl_in.cascade_sel)
    |-> lut_out.slice_mux_out_d === mem_reg[0][SRL_DEPTH-1])
    else $error("Cascade tap not routed to the d multiplexer");

  // Otherwise the d multiplexer carries the second lane's lookup.
  mux_d_lookup_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    !(ctrl_in.mode == lrsr_pkg::LRSR_MODE_SHIFT && ctrl_in.cascade_sel)
    |-> lut_out.slice_mux_out_d === lut_out.lookup[1])
    else $error("The d multiplexer does not follow the second lookup");

  // A bit shifted in at stage zero also shows on the a multiplexer.
  shift_mux_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (shift_edge && ctrl_in.addr == 5'h00 ##1 ctrl_in.addr == 5'h00
     && ctrl_in.mode == lrsr_pkg::LRSR_MODE_SHIFT)
    |-> lut_out.slice_mux_out_a == $past(bypass_data_in))
    else $error("Shifted bit not on the a multiplexer");

  // The carry output passes the first lane's lookup through.
  carry_follow_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    1'b1 |-> lut_out.carry_chain_out === lut_out.lookup[0])
    else $error("Carry output does not follow the first lookup");

  // The cascade tap is the last stage whatever the mode.
  tap_route_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    1'b1 |-> lut_out.cascade_tap_out === mem_reg[0][SRL_DEPTH-1])
    else $error("Cascade tap is not wired to the last stage");

  // A steady address clears the unknown flag at the next edge.
  valid_recover_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (!shift_edge && ctrl_in.addr == addr_prev_reg) |=> lut_out.read_valid)
    else $error("Read flag did not recover on a steady address");

  // An address move without a shift leaves the flag as it was.
  valid_hold_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (!shift_edge && ctrl_in.addr != addr_prev_reg) |=> lut_out.read_valid == $past(lut_out.read_valid))
    else $error("Read flag changed without a shift");

  // The second lane moves one stage per edge in the two-bit arrangement.
  lane_two_step_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (shift_edge && ctrl_in.wide) |=> mem_reg[1][SRL_DEPTH-1:1] === $past(mem_reg[1][SRL_DEPTH-2:0]))
    else $error("Second lane did not move one stage");

  // The new bit enters the first lane at stage zero.
  shift_entry_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    shift_edge |=> mem_reg[0][0] == $past(bypass_data_in))
    else $error("Shifted bit did not enter stage zero");

  // A RAM write outside the two-bit arrangement keeps the second lane.
  ram_lane_keep_a : assert property (
    @(posedge clk_in) disable iff (srst_in)
    (ram_edge && !ctrl_in.wide) |=> mem_reg[1] === $past(mem_reg[1]))
    else $error("Single-bit RAM write touched the second lane");

  // Reset must not touch contents, so this one stays live during reset.
  reset_keep_a : assert property (
    @(posedge clk_in)
    (srst_in && !ctrl_in.write_en) |=> mem_reg[0] === $past(mem_reg[0]) && mem_reg[1] === $past(mem_reg[1]))
    else $error("Reset disturbed stored contents");

  // Reset marks the addressable output as valid.
  valid_reset_a : assert property (
    @(posedge clk_in)
    srst_in |=> lut_out.read_valid)
    else $error("Read flag not set by reset");

endmodule // lrsr_lut_ram_shift

`default_nettype wire

//--- test/lrsr_user_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Surrounding user logic that drives the element.
// ****************************************************************
module lrsr_user_model (
  input wire logic clk_in,                // Element clock.
  output var lrsr_pkg::lrsr_ctrl_t ctrl_out,  // Mode, enables and address.
  output var logic bypass_out,                // First data bit.
  output var logic secondary_out              // Second data bit.
);
  // Quiet start: no write until the bench asks for one.
  initial begin
    ctrl_out = '0;
    bypass_out = 1'b0;
    secondary_out = 1'b0;
  end

  // One request a cycle, changed just after an edge and held until the next one.
  // Write enable stays low on every edge where contents must not move.
  task automatic drive(input logic shift, input logic we, input logic [4:0] addr,
                       input logic d0, input logic d1, input logic csel, input logic wide);
    @(posedge clk_in);
    ctrl_out <= '{lrsr_pkg::lrsr_mode_t'(shift), we, wide, csel, addr};
    bypass_out <= d0;
    secondary_out <= d1;
  endtask
endmodule // lrsr_user_model
`default_nettype wire

//--- test/lrsr_lut_ram_shift_tb.sv
`timescale 1ns/100ps
`default_nettype none

module lrsr_lut_ram_shift_tb;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  lrsr_pkg::lrsr_ctrl_t ctrl;
  logic b0;
  logic b1;
  lrsr_pkg::lrsr_out_t lut;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic mem0 [16];
  logic mem1 [16];
  logic sr0 [32];
  logic sr1 [32];

  // 200 MHz clock.
  always #2.5 clk_in = ~clk_in;

  lrsr_user_model i_lrsr_user_model (.clk_in(clk_in), .ctrl_out(ctrl), .bypass_out(b0),
    .secondary_out(b1));
  lrsr_lut_ram_shift i_lrsr_lut_ram_shift (.clk_in(clk_in), .srst_in(srst_in),
    .ctrl_in(ctrl), .bypass_data_in(b0), .secondary_data_in(b1), .lut_out(lut));

  // Hang guard: the whole run needs well under 200 cycles.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t output bit: expected %b got %b", $time, exp, got);
    end
  endtask

  // ****************************************************************
  // RAM: fill all locations in both lanes, then read back with stale data present.
  // ****************************************************************
  task automatic test_ram();
    for (int i = 0; i < 16; i++) begin
      mem0[i] = i[0] ^ i[2];
      mem1[i] = ~i[1];
      i_lrsr_user_model.drive(1'b0, 1'b1, {1'b1, i[3:0]}, mem0[i], mem1[i], 1'b0, 1'b1);
    end
    // Inverted data under a low enable must not land anywhere.
    i_lrsr_user_model.drive(1'b0, 1'b0, 5'h00, ~mem0[0], ~mem1[0], 1'b0, 1'b1);
    for (int i = 15; i >= 0; i--) begin
      i_lrsr_user_model.drive(1'b0, 1'b0, i[4:0], ~mem0[i], ~mem1[i], 1'b0, 1'b1);
      @(negedge clk_in);
      chk(mem0[i], lut.lookup[0]);
      chk(mem1[i], lut.lookup[1]);
      chk(mem0[i], lut.slice_mux_out_a);
      chk(mem0[i], lut.carry_chain_out);
    end
  endtask

  // ****************************************************************
  // Shift: 32 enabled edges, stage 0 watched, then every stage read back.
  // ****************************************************************
  task automatic test_shift();
    logic d0;
    logic d1;
    for (int k = 0; k < 32; k++) begin
      d0 = k[0] ^ k[3];
      d1 = ~k[1];
      i_lrsr_user_model.drive(1'b1, 1'b1, 5'h00, d0, d1, 1'b1, 1'b1);
      if (k > 0) begin
        @(negedge clk_in);
        chk(sr0[0], lut.lookup[0]);
        chk(sr1[0], lut.lookup[1]);
      end
      for (int j = 31; j > 0; j--) begin
        sr0[j] = sr0[j-1];
        sr1[j] = sr1[j-1];
      end
      sr0[0] = d0;
      sr1[0] = d1;
    end
    i_lrsr_user_model.drive(1'b1, 1'b0, 5'h1f, 1'b1, 1'b1, 1'b1, 1'b1);
    @(negedge clk_in);
    chk(1'b0, lut.cascade_tap_out);
    chk(1'b0, lut.slice_mux_out_d);
    for (int j = 0; j < 32; j++) begin
      i_lrsr_user_model.drive(1'b1, 1'b0, j[4:0], ~sr0[j], ~sr1[j], 1'b0, 1'b1);
      @(negedge clk_in);
      chk(sr0[j], lut.lookup[0]);
      chk(sr1[j], lut.slice_mux_out_d);
      chk(sr0[j], lut.slice_mux_out_a);
    end
    // Address moved across a shifting edge, then held steady for one edge.
    i_lrsr_user_model.drive(1'b1, 1'b1, 5'h05, 1'b0, 1'b0, 1'b0, 1'b1);
    i_lrsr_user_model.drive(1'b1, 1'b0, 5'h05, 1'b0, 1'b0, 1'b0, 1'b1);
    @(negedge clk_in);
    chk(1'b0, lut.read_valid);
    i_lrsr_user_model.drive(1'b1, 1'b0, 5'h05, 1'b0, 1'b0, 1'b0, 1'b1);
    @(negedge clk_in);
    chk(1'b1, lut.read_valid);
  endtask

  // ****************************************************************
  // Single-bit RAM: a write with the second lane off must leave that lane alone.
  // ****************************************************************
  task automatic test_narrow();
    mem0[3] = ~mem0[3];
    i_lrsr_user_model.drive(1'b0, 1'b1, 5'h03, mem0[3], ~mem1[3], 1'b0, 1'b0);
    i_lrsr_user_model.drive(1'b0, 1'b0, 5'h03, 1'b0, 1'b0, 1'b0, 1'b1);
    @(negedge clk_in);
    chk(mem0[3], lut.lookup[0]);
    chk(mem1[3], lut.lookup[1]);
    chk(1'b1, lut.read_valid);
  endtask

  task automatic print_verdict();
    $display("Errors: %0d  Comparisons: %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence: contents have no reset, so every read follows a write or a shift.
  initial begin
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    test_ram();
    test_narrow();
    test_shift();
    print_verdict();
  end
endmodule // lrsr_lut_ram_shift_tb
`default_nettype wire
